// ---- common/srr_pkg.sv ----
// Shared constants, types and helpers for the routing information field processor
package srr_pkg;

    // ********************************************************
    // Field geometry
    // ********************************************************
    localparam int            RI_BYTES     = 30;
    localparam int            RI_W         = 8 * RI_BYTES;
    localparam int            MAX_RD       = 14;
    localparam int            ADDR_W       = 8;
    localparam int            DATA_W       = 32;
    localparam logic [4:0]    LTH_MIN      = 5'h02;
    localparam logic [4:0]    LTH_MAX      = 5'h1E;
    localparam logic [4:0]    LTH_STEP     = 5'h02;
    localparam logic [3:0]    BN_LAST      = 4'h0;

    // ********************************************************
    // Register map
    // ********************************************************
    localparam logic [7:0]    OFS_CTRL     = 8'h00;
    localparam logic [7:0]    OFS_BR_MSDU  = 8'h04;
    localparam logic [7:0]    OFS_PRIO_MAP = 8'h08;
    localparam logic [7:0]    OFS_STATUS   = 8'h0C;
    localparam logic [7:0]    OFS_FWD_CNT  = 8'h10;
    localparam logic [7:0]    OFS_DISC_CNT = 8'h14;
    localparam int            CTRL_LF_EXT  = 0;
    localparam logic [0:0]    RST_CTRL     = 1'h0;
    localparam logic [15:0]   RST_BR_MSDU  = 16'hFFFF;
    localparam logic [23:0]   RST_PRIO_MAP = 24'hFA_C688;

    // Largest frame base values, plus the value that follows the top code
    localparam logic [15:0]   LF_BASE [0:8] = '{16'h0204, 16'h05BE, 16'h0804, 16'h112F,
                                                16'h1FC2, 16'h2C8F, 16'h4555, 16'hA280, 16'hFFFF};

    typedef enum logic [2:0] {
        SRR_VD_NONE  = 3'h0,
        SRR_VD_FWD   = 3'h1,
        SRR_VD_LEN   = 3'h2,
        SRR_VD_DIR   = 3'h3,
        SRR_VD_ROUTE = 3'h4,
        SRR_VD_STATE = 3'h5,
        SRR_VD_FULL  = 3'h6
    } srr_verdict_t;

    typedef struct packed {
        logic            valid;
        logic            rii;
        logic [2:0]      prio;
        logic [RI_W-1:0] ri;
    } srr_rx_t;

    typedef struct packed {
        logic [11:0]     lin;
        logic [11:0]     lout;
        logic [3:0]      bn;
        logic [15:0]     rx_msdu;
        logic [15:0]     tx_msdu;
        logic            rx_fwd;
        logic            tx_fwd;
    } srr_port_t;

    typedef struct packed {
        logic            valid;
        logic            sr_path;
        logic            forward;
        logic            fcs_redo;
        logic [2:0]      prio;
        logic [RI_W-1:0] ri;
    } srr_tx_t;

    // Size in octets carried by a six-bit largest frame code
    function automatic logic [15:0] srr_lf_value(input logic [5:0] code);
        logic [19:0] span;
        span = 20'(LF_BASE[int'(code[5:3]) + 1] - LF_BASE[int'(code[5:3])]) * 20'(code[2:0]);
        return 16'(LF_BASE[int'(code[5:3])] + 16'(span[19:3]));
    endfunction

endpackage

// ---- dv/srr_mac_model.sv ----
// Far side model: the port MAC entities that hand received frames to the relay
`timescale 1ns/1ps
module srr_mac_model (
    output srr_pkg::srr_rx_t   rx_in,
    output srr_pkg::srr_port_t port_cfg,
    input  wire logic          clock
);
    import srr_pkg::*;

    initial begin
        rx_in    = '0;
        port_cfg = '0;
    end

    // ************************************************
    // Frame indication
    // ************************************************
    // Keep leaves no idle cycle, so the next call lands back to back
    task automatic send(input logic rii, input logic [2:0] prio, input logic [RI_W-1:0] ri,
                        input srr_port_t p, input logic keep);
        @(posedge clock);
        rx_in    <= '{valid: 1'b1, rii: rii, prio: prio, ri: ri};
        port_cfg <= p;
        if (!keep) begin
            @(posedge clock);
            // Released fields turn over so a stale frame never looks current
            rx_in    <= '{valid: 1'b0, rii: ~rii, prio: ~prio, ri: ~ri};
            port_cfg <= ~p;
        end
    endtask
endmodule // srr_mac_model

// ---- dv/srr_ri_proc_test.sv ----
// Self-checking testbench for the routing information field processor
`timescale 1ns/1ps
module srr_ri_proc_test;
    import srr_pkg::*;

    typedef struct packed {
        logic            rii;
        logic            fwd;
        logic [2:0]      prio;
        logic [RI_W-1:0] ri;
        logic [RI_W-1:0] m;
    } srr_exp_t;

    logic              clock;
    logic              reset;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    srr_rx_t           rx_in;
    srr_port_t         port_cfg;
    srr_tx_t           tx_out;
    srr_exp_t          q[$];
    srr_exp_t          e_mon;
    logic [1:0]        dv;
    logic              ctrl_m;
    logic [23:0]       map_m;
    logic [15:0]       brm_m;
    int                fail_count;
    int                cmp_count;
    int                n_fwd;
    int                n_disc;

    srr_ri_proc u_dut (.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_in(rx_in), .port_cfg(port_cfg),
        .tx_out(tx_out));
    srr_mac_model u_mac (.rx_in(rx_in), .port_cfg(port_cfg), .clock(clock));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // ************************************************
    // Expectation helpers
    // ************************************************
    function automatic int lfv(input logic [5:0] c);
        int b [9] = '{516, 1470, 2052, 4399, 8130, 11407, 17749, 41600, 65535};
        return b[c[5:3]] + (int'(c[2:0]) * (b[c[5:3] + 1] - b[c[5:3]])) / 8;
    endfunction

    function automatic logic [5:0] clamp(input logic [5:0] c, input srr_port_t p);
        int         m;
        logic [5:0] r;
        m = lfv(c);
        r = '0;
        if (int'(brm_m) < m) m = int'(brm_m);
        if (int'(p.rx_msdu) < m) m = int'(p.rx_msdu);
        if (int'(p.tx_msdu) < m) m = int'(p.tx_msdu);
        for (int k = 0; k < 64; k++) if ((ctrl_m || k % 8 == 0) && lfv(6'(k)) <= m) r = 6'(k);
        return r;
    endfunction

    function automatic srr_exp_t exp_of(input logic rii, input logic [2:0] pr, input logic [RI_W-1:0] ri,
                                        input srr_port_t p);
        srr_exp_t    e;
        int          n;
        int          L;
        logic [15:0] a;
        logic [15:0] b;
        e = '{rii: rii, fwd: 1'b1, prio: rii ? map_m[3 * pr +: 3] : pr, ri: ri, m: '1};
        L = int'(ri[236:232]);
        n = L / 2 - 1;
        if (!rii) return e;
        a = (L > 2) ? ri[223 - 16 * (n - 1) -: 16] : {p.lin, 4'h0};
        if (L % 2 == 1 || L < 2) e.fwd = 1'b0;
        else if (!ri[239]) begin
            e.fwd = 1'b0;
            for (int i = 0; i + 1 < n; i++) begin
                a = ri[223 - 16 * i -: 16];
                b = ri[207 - 16 * i -: 16];
                if (ri[231] ? (a == {p.lout, p.bn} && b[15:4] == p.lin) : (a == {p.lin, p.bn} && b[15:4] == p.lout))
                    e.fwd = 1'b1;
            end
        end else if (ri[231] || (ri[238] && !(p.rx_fwd && p.tx_fwd)) || L > 28 || a[15:4] != p.lin)
            e.fwd = 1'b0;
        else begin
            if (L == 2) begin
                e.ri[223 -: 16] = {p.lin, p.bn};
                n = 1;
            end else e.ri[211 - 16 * (n - 1) -: 4] = p.bn;
            e.ri[223 - 16 * n -: 16] = {p.lout, 4'h0};
            L = 2 * n + 4;
            e.ri[236:232] = 5'(L);
            e.ri[230:225] = clamp(ri[230:225], p);
            e.m = ~({RI_W{1'b1}} >> (8 * L));
        end
        return e;
    endfunction

    function automatic logic [15:0] sz();
        return ($urandom % 2 == 1) ? 16'(lfv(6'($urandom))) : 16'($urandom_range(400, 65535));
    endfunction

    // ************************************************
    // Drivers and checks
    // ************************************************
    task automatic check(input logic [RI_W-1:0] seen, input logic [RI_W-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
        @(negedge clock);
        check(RI_W'(reg_rdata), RI_W'(x));
        @(negedge clock);
        check(RI_W'(reg_rdata), '0);
    endtask

    task automatic frame(input logic rii, input logic [2:0] pr, input logic [RI_W-1:0] ri,
                         input srr_port_t p, input logic keep);
        srr_exp_t e;
        e = exp_of(rii, pr, ri, p);
        q.push_back(e);
        if (rii && e.fwd) n_fwd++;
        if (rii && !e.fwd) n_disc++;
        u_mac.send(rii, pr, ri, p, keep);
    endtask

    task automatic rnd_frame(input logic keep);
        logic [RI_W-1:0] ri;
        srr_port_t       p;
        int              n;
        int              k;
        logic [4:0]      L;
        for (int w = 0; w < RI_W / 16; w++) ri[16 * w +: 16] = 16'($urandom);
        L = ($urandom % 8 == 0) ? 5'($urandom) : 5'(2 * $urandom_range(1, 15));
        n = int'(L) / 2 - 1;
        ri[239:225] = {3'($urandom), L, 1'b0, 6'($urandom)};
        ri[231] = ($urandom % (ri[239] ? 10 : 2) == 0);
        p = '{lin: 12'h0A1, lout: 12'h0B2, bn: 4'($urandom_range(1, 15)), rx_msdu: sz(), tx_msdu: sz(),
              rx_fwd: ($urandom % 4 != 0), tx_fwd: ($urandom % 4 != 0)};
        if (ri[239] && n > 0 && $urandom % 8 != 0) ri[223 - 16 * (n - 1) -: 16] = {p.lin, 4'h0};
        if (!ri[239] && n >= 2 && $urandom % 4 != 0) begin
            k = $urandom_range(0, n - 2);
            ri[223 - 16 * k -: 16] = {ri[231] ? p.lout : p.lin, p.bn};
            ri[207 - 16 * k -: 12] = ri[231] ? p.lin : p.lout;
        end
        frame($urandom % 6 != 0, 3'($urandom), ri, p, keep);
    endtask

    always @(posedge clock) dv <= reset ? 2'b00 : {dv[0], rx_in.valid};

    always @(negedge clock) begin
        if (reset === 1'b0) begin
            check(RI_W'(tx_out.valid), RI_W'(dv[1]));
            if (tx_out.valid === 1'b1 && q.size() > 0) begin
                e_mon = q.pop_front();
                check(RI_W'(tx_out.sr_path), RI_W'(e_mon.rii));
                check(RI_W'(tx_out.forward), RI_W'(e_mon.fwd));
                check(RI_W'(tx_out.prio), RI_W'(e_mon.prio));
                check(tx_out.ri & e_mon.m, e_mon.ri & e_mon.m);
                check(RI_W'(tx_out.fcs_redo), RI_W'(e_mon.rii && e_mon.fwd && e_mon.ri[239]));
            end
        end
    end

    // ************************************************
    // Test sequence
    // ************************************************
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Whole run is a few hundred cycles; twenty thousand means a hang
    initial begin
        #1_000_000;
        fail_count++;
        summarize();
    end

    initial begin
        logic [7:0]  ra [6] = '{OFS_CTRL, OFS_BR_MSDU, OFS_PRIO_MAP, OFS_FWD_CNT, OFS_DISC_CNT, 8'h18};
        logic [31:0] rv [6] = '{32'h0000_0000, 32'h0000_FFFF, 32'h00FA_C688, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
        reset = 1'b1;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        {fail_count, cmp_count, n_fwd, n_disc} = '0;
        ctrl_m = 1'b0;
        map_m = 24'hFA_C688;
        brm_m = 16'hFFFF;
        void'($urandom(48595));
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        for (int i = 0; i < 6; i++) rdc(ra[i], rv[i]);
        wr(8'h18, $urandom);
        rdc(8'h18, 32'h0000_0000);
        $display("test registers done");
        frame(1'b1, 3'h0, {8'h05, 232'h0}, '{lin: 12'h0A1, lout: 12'h0B2, bn: 4'h1, default: '1}, 1'b0);
        repeat (4) @(posedge clock);
        rdc(OFS_STATUS, 32'h0000_002A);
        $display("test length discard done");
        for (int t = 0; t < 2; t++) begin
            if (t == 1) begin
                ctrl_m = 1'b1;
                map_m = 24'($urandom);
                brm_m = sz();
                wr(OFS_CTRL, 32'h0000_0001);
                wr(OFS_BR_MSDU, 32'(brm_m));
                wr(OFS_PRIO_MAP, 32'(map_m));
            end
            for (int i = 0; i < 120; i++) rnd_frame(i % 4 != 3);
            repeat (4) @(posedge clock);
            $display("test random frames pass %0d done", t);
        end
        rdc(OFS_FWD_CNT, 32'(n_fwd));
        rdc(OFS_DISC_CNT, 32'(n_disc));
        @(posedge clock);
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        rdc(OFS_CTRL, 32'h0000_0000);
        $display("test second reset done");
        summarize();
    end
endmodule // srr_ri_proc_test

// ---- rtl/srr_ri_proc.sv ----
// Routing information field checker and updater for a source routing bridge port pair
`timescale 1ns/1ps
//
// Function
// - Top routing-type bit 0: specifically routed, low two bits kept.
// - Type 10X: all-routes explorer, descriptors appended, low bit kept.
// - Type 11X: spanning explorer relayed only between forwarding ports.
// - Length field is even, from 2 to 30 octets.
// - Direction 0 walks descriptors forward, 1 walks them backward.
// - Explorer frames must carry direction bit 0.
// - Specifically routed frames keep largest-frame bits untouched.
// - Explorer largest-frame set to best code under minimum of four sizes.
// - Largest-frame code is 3-bit base plus 3-bit extension in octet two.
// - Mode setting picks base-only or extended code set.
// - Base codes map to fixed octet sizes, 516 up to above 17749.
// - Extended value is base plus extension eighths of the gap.
// - Descriptor is 12-bit LAN identifier then 4-bit bridge number.
// - Bridge number of the final descriptor is written as zero.
// - Reserved bits are ignored and passed on as received.
// - Spanning explorers get no destination address filtering.
// - Frames without routing info go transparent, others to source routing.
// - Frames with routing info get their user priority regenerated.
// - Reception stage then forwarding stage, in sequence.
// - A hop is receiving LAN, bridge number, transmitting LAN.
// - A modified explorer is flagged for check sequence regeneration.
module srr_ri_proc (
    input  wire logic                       clock,
    input  wire logic                       reset,
    input  wire logic [srr_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [srr_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [srr_pkg::DATA_W-1:0] reg_rdata,
    input  wire srr_pkg::srr_rx_t           rx_in,
    input  wire srr_pkg::srr_port_t         port_cfg,
    output srr_pkg::srr_tx_t                tx_out
);
    import srr_pkg::*;

    // ********************************************************
    // Register file
    // ********************************************************
    logic [0:0]        ctrl_reg;
    logic [15:0]       br_msdu_reg;
    logic [23:0]       prio_map_reg;
    logic [31:0]       fwd_cnt_reg;
    logic [31:0]       disc_cnt_reg;
    srr_verdict_t      verdict_reg;
    logic [4:0]        last_lth_reg;
    logic [DATA_W-1:0] rdata_next;
    srr_tx_t           tx_reg;
    srr_tx_t           tx_next;
    srr_verdict_t      verdict_next;

    always_ff @(posedge clock) begin
        if (reset) begin
            ctrl_reg     <= RST_CTRL;
            br_msdu_reg  <= RST_BR_MSDU;
            prio_map_reg <= RST_PRIO_MAP;
        end else if (reg_wr) begin
            unique case (reg_addr)
                OFS_CTRL:     ctrl_reg     <= reg_wdata[CTRL_LF_EXT:CTRL_LF_EXT];
                OFS_BR_MSDU:  br_msdu_reg  <= reg_wdata[15:0];
                OFS_PRIO_MAP: prio_map_reg <= reg_wdata[23:0];
                default:      ;
            endcase
        end
    end

    always_comb begin
        rdata_next = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_CTRL:     rdata_next = {31'h0000_0000, ctrl_reg};
                OFS_BR_MSDU:  rdata_next = {16'h0000, br_msdu_reg};
                OFS_PRIO_MAP: rdata_next = {8'h00, prio_map_reg};
                OFS_STATUS:   rdata_next = {24'h00_0000, last_lth_reg, verdict_reg};
                OFS_FWD_CNT:  rdata_next = fwd_cnt_reg;
                OFS_DISC_CNT: rdata_next = disc_cnt_reg;
                default:      rdata_next = '0;
            endcase
        end
    end

    // Read data only stands in the cycle after the strobe
    always_ff @(posedge clock) begin
        if (reset) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= rdata_next;
        end
    end

    // ********************************************************
    // Reception stage
    // ********************************************************
    srr_rx_t   s1_reg;
    srr_port_t cfg_reg;

    always_ff @(posedge clock) begin
        if (reset) begin
            s1_reg  <= '0;
            cfg_reg <= '0;
        end else begin
            s1_reg  <= rx_in;
            cfg_reg <= port_cfg;
        end
    end

    // ********************************************************
    // Forwarding stage: field decode
    // ********************************************************
    logic [2:0]  rt;
    logic [4:0]  lth;
    logic        dir;
    logic [5:0]  lf_rx;
    logic        resv;
    logic        explorer;
    logic        len_ok;
    logic [3:0]  rd_cnt;
    logic [3:0]  last_idx;
    logic        short_ri;

    assign rt       = s1_reg.ri[RI_W-1 -: 3];
    assign lth      = s1_reg.ri[RI_W-4 -: 5];
    assign dir      = s1_reg.ri[RI_W-9];
    assign lf_rx    = s1_reg.ri[RI_W-10 -: 6];
    assign resv     = s1_reg.ri[RI_W-16];
    assign explorer = rt[2];
    assign len_ok   = !lth[0] && (lth >= LTH_MIN) && (lth <= LTH_MAX);
    assign rd_cnt   = lth[4:1] - 4'h1;
    assign last_idx = rd_cnt - 4'h1;
    assign short_ri = (lth == LTH_MIN);

    // ********************************************************
    // Route descriptors, one slice per entry
    // ********************************************************
    logic [15:0]       rd_in  [MAX_RD];
    logic [15:0]       rd_new [MAX_RD];
    logic [MAX_RD-2:0] hop_hit;

    genvar j;
    generate
        for (j = 0; j < MAX_RD; j++) begin : g_rd
            assign rd_in[j] = s1_reg.ri[RI_W-17-16*j -: 16];
            always_comb begin
                rd_new[j] = rd_in[j];
                if (short_ri) begin
                    if (j == 0) begin
                        rd_new[j] = {cfg_reg.lin, cfg_reg.bn};
                    end else if (j == 1) begin
                        rd_new[j] = {cfg_reg.lout, BN_LAST};
                    end
                end else if (4'(j) == last_idx) begin
                    rd_new[j] = {rd_in[j][15:4], cfg_reg.bn};
                end else if (4'(j) == rd_cnt) begin
                    rd_new[j] = {cfg_reg.lout, BN_LAST};
                end
            end
            if (j < MAX_RD - 1) begin : g_hop
                // Reverse walk swaps which LAN comes first in the pair
                assign hop_hit[j] = (4'(j) + 4'h1 < rd_cnt) && (rd_in[j][3:0] == cfg_reg.bn) &&
                    (dir ? (rd_in[j][15:4] == cfg_reg.lout && rd_in[j+1][15:4] == cfg_reg.lin)
                         : (rd_in[j][15:4] == cfg_reg.lin && rd_in[j+1][15:4] == cfg_reg.lout));
            end
        end
    endgenerate

    logic        last_lan_ok;
    logic [11:0] last_lan;
    assign last_lan    = s1_reg.ri[RI_W-17-16*int'(last_idx) -: 12];
    assign last_lan_ok = short_ri || (last_lan == cfg_reg.lin);

    // ********************************************************
    // Largest frame clamp
    // ********************************************************
    logic [15:0] size_min;
    logic [5:0]  lf_best;

    always_comb begin
        size_min = srr_lf_value(lf_rx);
        if (br_msdu_reg < size_min) begin
            size_min = br_msdu_reg;
        end
        if (cfg_reg.rx_msdu < size_min) begin
            size_min = cfg_reg.rx_msdu;
        end
        if (cfg_reg.tx_msdu < size_min) begin
            size_min = cfg_reg.tx_msdu;
        end
    end

    // Scan all 64 codes; base mode skips any code with extension bits set
    always_comb begin
        lf_best = 6'h00;
        for (int c = 0; c < 64; c++) begin
            if ((ctrl_reg[0] || (c % 8 == 0)) && srr_lf_value(6'(c)) <= size_min) begin
                lf_best = 6'(c);
            end
        end
    end

    // ********************************************************
    // Forwarding decision and rebuilt field
    // ********************************************************
    logic [RI_W-1:0] ri_built;
    logic [4:0]      lth_new;

    assign lth_new = short_ri ? (lth + LTH_STEP + LTH_STEP) : (lth + LTH_STEP);

    always_comb begin
        ri_built = s1_reg.ri;
        // Routing type bits and reserved bit go out exactly as received
        ri_built[RI_W-1 -: 16] = {rt, lth_new, dir, lf_best, resv};
        for (int k = 0; k < MAX_RD; k++) begin
            ri_built[RI_W-17-16*k -: 16] = rd_new[k];
        end
    end

    always_comb begin
        verdict_next = SRR_VD_NONE;
        tx_next      = '0;
        tx_next.valid   = s1_reg.valid;
        tx_next.sr_path = s1_reg.rii;
        tx_next.prio    = s1_reg.prio;
        tx_next.ri      = s1_reg.ri;
        if (s1_reg.valid && !s1_reg.rii) begin
            tx_next.forward = 1'b1;
        end else if (s1_reg.valid) begin
            tx_next.prio = prio_map_reg[3*int'(s1_reg.prio) +: 3];
            if (!len_ok) begin
                verdict_next = SRR_VD_LEN;
            end else if (!explorer) begin
                // Specifically routed: field left untouched, largest frame ignored
                verdict_next = (|hop_hit) ? SRR_VD_FWD : SRR_VD_ROUTE;
            end else if (dir) begin
                verdict_next = SRR_VD_DIR;
            end else if (rt[1] && !(cfg_reg.rx_fwd && cfg_reg.tx_fwd)) begin
                // No address filter here: port state alone gates the relay
                verdict_next = SRR_VD_STATE;
            end else if (!last_lan_ok) begin
                verdict_next = SRR_VD_ROUTE;
            end else if (lth_new > LTH_MAX || lth_new < lth) begin
                verdict_next = SRR_VD_FULL;
            end else begin
                verdict_next     = SRR_VD_FWD;
                tx_next.ri       = ri_built;
                tx_next.fcs_redo = 1'b1;
            end
            tx_next.forward = (verdict_next == SRR_VD_FWD);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            tx_reg <= '0;
        end else begin
            tx_reg <= tx_next;
        end
    end

    assign tx_out = tx_reg;

    // ********************************************************
    // Status and counters
    // ********************************************************
    always_ff @(posedge clock) begin
        if (reset) begin
            verdict_reg  <= SRR_VD_NONE;
            last_lth_reg <= '0;
            fwd_cnt_reg  <= '0;
            disc_cnt_reg <= '0;
        end else if (s1_reg.valid && s1_reg.rii) begin
            verdict_reg  <= verdict_next;
            last_lth_reg <= lth;
            if (verdict_next == SRR_VD_FWD) begin
                fwd_cnt_reg <= fwd_cnt_reg + 32'h0000_0001;
            end else begin
                disc_cnt_reg <= disc_cnt_reg + 32'h0000_0001;
            end
        end
    end

    // ********************************************************
    // Assertions
    // ********************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence rx_routed_s;
        rx_in.valid && rx_in.rii;
    endsequence

    sequence tx_explorer_fwd_s;
        tx_out.valid && tx_out.sr_path && tx_out.forward && tx_out.ri[RI_W-1];
    endsequence

    pipe_latency_a: assert property (rx_in.valid |-> ##2 tx_out.valid)
        else $error("Frame did not leave two cycles after reception");

    transparent_path_a: assert property (rx_in.valid && !rx_in.rii |-> ##2 (!tx_out.sr_path && tx_out.forward))
        else $error("Frame without routing info not sent transparent");

    srf_unaltered_a: assert property (rx_routed_s ##0 !rx_in.ri[RI_W-1] |-> ##2 tx_out.ri == $past(rx_in.ri, 2))
        else $error("Specifically routed field was altered");

    explorer_dir_a: assert property (tx_explorer_fwd_s |-> !tx_out.ri[RI_W-9])
        else $error("Explorer forwarded with direction bit set");

    length_range_a: assert property (tx_out.valid && tx_out.sr_path && tx_out.forward |->
        !tx_out.ri[RI_W-8] && tx_out.ri[RI_W-4 -: 5] >= LTH_MIN)
        else $error("Forwarded field length out of range");

    base_mode_a: assert property (tx_explorer_fwd_s ##0 $past(ctrl_reg[0]) == 1'b0 |->
        tx_out.ri[RI_W-13 -: 3] == 3'h0)
        else $error("Extended code written in base mode");

    lf_clamp_a: assert property (tx_explorer_fwd_s |->
        srr_lf_value(tx_out.ri[RI_W-10 -: 6]) <= $past(size_min))
        else $error("Largest frame exceeds the computed minimum");

    ste_state_a: assert property (tx_explorer_fwd_s ##0 tx_out.ri[RI_W-2] |->
        $past(cfg_reg.rx_fwd && cfg_reg.tx_fwd))
        else $error("Spanning explorer relayed through a blocked port");

    fcs_flag_a: assert property (tx_explorer_fwd_s |-> tx_out.fcs_redo)
        else $error("Modified explorer not flagged for check sequence");

    type_keep_a: assert property (rx_routed_s |-> ##2 tx_out.ri[RI_W-1 -: 3] == $past(rx_in.ri[RI_W-1 -: 3], 2))
        else $error("Routing type bits changed");

    // Explorer seen at reception
    sequence rx_explorer_s;
        rx_routed_s ##0 rx_in.ri[RI_W-1];
    endsequence

    // Outgoing index of the last descriptor
    logic [3:0] tx_rd_last;
    assign tx_rd_last = tx_out.ri[RI_W-4 -: 4] - 4'h2;

    // Every discard path keeps forward low, whatever else the field holds
    len_discard_a: assert property (rx_routed_s ##0 (rx_in.ri[RI_W-8] || rx_in.ri[RI_W-4 -: 5] < LTH_MIN)
        |-> ##2 !tx_out.forward)
        else $error("Bad length forwarded");

    dir_discard_a: assert property (rx_explorer_s ##0 rx_in.ri[RI_W-9] |-> ##2 !tx_out.forward)
        else $error("Explorer with direction set forwarded");

    ste_block_a: assert property (rx_explorer_s ##0
        (rx_in.ri[RI_W-2] && !(port_cfg.rx_fwd && port_cfg.tx_fwd)) |-> ##2 !tx_out.forward)
        else $error("Spanning explorer crossed a blocked port");

    resv_keep_a: assert property (rx_routed_s |-> ##2 tx_out.ri[RI_W-16] == $past(rx_in.ri[RI_W-16], 2))
        else $error("Reserved bit changed");

    plain_prio_a: assert property (rx_in.valid && !rx_in.rii |-> ##2 tx_out.prio == $past(rx_in.prio, 2))
        else $error("Plain frame priority changed");

    last_bn_zero_a: assert property (tx_explorer_fwd_s |->
        tx_out.ri[RI_W-29-16*int'(tx_rd_last) -: 4] == BN_LAST)
        else $error("Final bridge number not zero");

    explorer_grow_a: assert property (tx_explorer_fwd_s |-> tx_out.ri[RI_W-4 -: 5] >= 5'h06)
        else $error("Relayed explorer too short");

    fcs_quiet_a: assert property (tx_out.valid && !(tx_out.sr_path && tx_out.forward && tx_out.ri[RI_W-1])
        |-> !tx_out.fcs_redo)
        else $error("Check sequence flagged on unmodified frame");

endmodule // srr_ri_proc
